// File: hw/qdac_params.svh
// Purpose: constants of the quad dac write command unit
// Assumes: 50 MHz system clock
// Notes: definitions only
`ifndef QDAC_PARAMS_SVH
`define QDAC_PARAMS_SVH
`define QDAC_CLK_MHZ 50
`define QDAC_PU_SHORT_US 5
`define QDAC_PU_LONG5_US 12
`define QDAC_PU_LONG3_US 30
`define QDAC_SENSE_CYC 16
`define QDAC_GLOBAL_ADDR 7'h73
`define QDAC_OFS_CTRL 8'h00
`define QDAC_OFS_STATUS 8'h04
`define QDAC_OFS_WORD 8'h08
`define QDAC_PAGE_DAC 4'h1
`define QDAC_PAGE_INPUT 4'h2
`define QDAC_CTRL_LOW_SUPPLY 0
`define QDAC_CTRL_RST 1'b0
`define QDAC_CODE_ZERO 16'h0000
`define QDAC_CODE_MID 16'h8000
`endif

// File: hw/qdac_pkg.sv
// Purpose: types of the quad dac write command unit
// Assumes: nothing
// Notes: command codes as sent on the wire, bus and sense states
package qdac_pkg;
  typedef logic [15:0] qdac_code_t;
  typedef enum logic [3:0] {
    QDAC_CMD_WRITE = 4'h0,
    QDAC_CMD_UPDATE = 4'h1,
    QDAC_CMD_WRITE_UPD_ALL = 4'h2,
    QDAC_CMD_WRITE_UPD = 4'h3,
    QDAC_CMD_POWER_DOWN = 4'h4,
    QDAC_CMD_NOP = 4'hf
  } qdac_cmd_t;
  typedef enum {QDAC_I2C_IDLE, QDAC_I2C_ADDR, QDAC_I2C_DATA,
                QDAC_I2C_ACK, QDAC_I2C_SKIP} qdac_i2c_st_t;
  typedef enum {QDAC_SENSE_HI, QDAC_SENSE_LO,
                QDAC_SENSE_DONE} qdac_sense_st_t;
endpackage : qdac_pkg

// File: hw/qdac_sync.sv
// Purpose: two flip-flop synchroniser per bit
// Assumes: inputs asynchronous to sys_clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module qdac_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  // one pair of stages per bit
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        meta_q[i] <= RST_VAL[i];
        sync_out[i] <= RST_VAL[i];
      end else begin
        meta_q[i] <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end
endmodule : qdac_sync

// File: hw/qdac_addr.sv
// Purpose: three-state address pin sensing and slave address
// Assumes: pins have a weak bench pull only when floating
// Notes: pins are driven high then low; a pin that follows floats
`timescale 1ns/1ps
`include "qdac_params.svh"
module qdac_addr (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe_n,
  output logic [6:0] own_addr,
  output logic addr_ready
);
  import qdac_pkg::*;
  qdac_sense_st_t st_q;
  logic [7:0] cnt_q;
  logic [2:0] pin_s;
  logic [2:0] hi_q;
  logic [2:0] lo_q;
  logic [1:0] trit [3];
  logic [4:0] idx;

  qdac_sync #(.WIDTH(3), .RST_VAL(3'h0)) u_pin_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in(pin_in),
    .sync_out(pin_s)
  );

  // sense after reset release; pins are probed, never trusted at reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= QDAC_SENSE_HI;
      cnt_q <= 8'h00;
      hi_q <= 3'h0;
      lo_q <= 3'h0;
    end else if (st_q != QDAC_SENSE_DONE) begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q == 8'(`QDAC_SENSE_CYC)) begin
        cnt_q <= 8'h00;
        if (st_q == QDAC_SENSE_HI) begin
          hi_q <= pin_s;
          st_q <= QDAC_SENSE_LO;
        end else begin
          lo_q <= pin_s;
          st_q <= QDAC_SENSE_DONE;
        end
      end
    end
  end

  // gnd 0, float 1, vcc 2
  for (genvar i = 0; i < 3; i++) begin : g_trit
    assign trit[i] = (hi_q[i] && lo_q[i]) ? 2'd2 :
                     (!hi_q[i] && !lo_q[i]) ? 2'd0 : 2'd1;
  end

  // 27 addresses run in groups of four per upper nibble
  assign idx = 5'(trit[2] * 9 + trit[1] * 3 + trit[0]);
  assign own_addr = {3'(idx[4:2] + 3'h1), 2'b00, idx[1:0]};
  assign addr_ready = (st_q == QDAC_SENSE_DONE);
  assign pin_out = (st_q == QDAC_SENSE_HI) ? 3'h7 : 3'h0;
  assign pin_oe_n = addr_ready ? 3'h7 : 3'h0;
endmodule : qdac_addr

// File: hw/qdac_top.sv
// Purpose: i2c write-only command unit of a quad dac
// Assumes: scl and sda asynchronous, 2-ff synchronised
// Notes: registers readable over ahb-lite, zero wait states
`timescale 1ns/1ps
`include "qdac_params.svh"
module qdac_top #(
  parameter bit MIDSCALE_RESET = 1'b0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_select_pin_0_in,
  output logic addr_select_pin_0_out,
  output logic addr_select_pin_0_oe_n,
  input wire logic addr_select_pin_1_in,
  output logic addr_select_pin_1_out,
  output logic addr_select_pin_1_oe_n,
  input wire logic addr_select_pin_2_in,
  output logic addr_select_pin_2_out,
  output logic addr_select_pin_2_oe_n,
  output qdac_pkg::qdac_code_t dac_code [4],
  output logic [3:0] chan_buf_en,
  output logic [3:0] channel_reference_input_en,
  output logic [3:0] chan_out_hiz,
  output logic [3:0] chan_settling,
  output logic bias_en
);
  import qdac_pkg::*;
  localparam logic [10:0] PU_SHORT_CYC =
    11'(`QDAC_PU_SHORT_US * `QDAC_CLK_MHZ);
  localparam logic [10:0] PU_LONG5_CYC =
    11'(`QDAC_PU_LONG5_US * `QDAC_CLK_MHZ);
  localparam logic [10:0] PU_LONG3_CYC =
    11'(`QDAC_PU_LONG3_US * `QDAC_CLK_MHZ);
  localparam qdac_code_t RST_CODE =
    MIDSCALE_RESET ? `QDAC_CODE_MID : `QDAC_CODE_ZERO;

  logic [1:0] bus_s;
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [6:0] own_addr;
  logic addr_ready;
  logic addr_hit;
  logic byte_done;
  qdac_i2c_st_t st_q;
  logic [3:0] bit_cnt_q;
  logic [1:0] byte_cnt_q;
  logic [7:0] shift_q;
  logic [23:0] word_q;
  logic exec_q;
  logic [3:0] cmd;
  logic [3:0] sel;
  qdac_code_t data;
  logic [3:0] sel_mask;
  logic [3:0] wr_mask;
  logic [3:0] upd_mask;
  logic [3:0] pd_mask;
  logic [10:0] pu_delay;
  qdac_code_t input_q [4];
  qdac_code_t dac_q [4];
  logic [3:0] pd_q;
  logic [10:0] pu_cnt_q [4];
  logic low_supply_q;
  logic ahb_wr_q;
  logic [7:0] ahb_addr_q;
  logic ahb_take;

  qdac_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_bus_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in({scl_in, sda_in}),
    .sync_out(bus_s)
  );

  qdac_addr u_addr (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_in({addr_select_pin_2_in, addr_select_pin_1_in,
             addr_select_pin_0_in}),
    .pin_out({addr_select_pin_2_out, addr_select_pin_1_out,
              addr_select_pin_0_out}),
    .pin_oe_n({addr_select_pin_2_oe_n, addr_select_pin_1_oe_n,
               addr_select_pin_0_oe_n}),
    .own_addr(own_addr),
    .addr_ready(addr_ready)
  );

  // edge history of the synchronised bus lines
  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  assign start_det = scl_s && scl_p_q && !sda_s && sda_p_q;
  assign stop_det = scl_s && scl_p_q && sda_s && !sda_p_q;
  assign byte_done = scl_fall && (bit_cnt_q == 4'd8);
  // write bit must be zero; a read is left unanswered
  assign addr_hit = addr_ready && !shift_q[0] &&
    ((shift_q[7:1] == own_addr) ||
     (shift_q[7:1] == `QDAC_GLOBAL_ADDR));

  // byte receiver and acknowledge driver
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= QDAC_I2C_IDLE;
      bit_cnt_q <= 4'h0;
      byte_cnt_q <= 2'h0;
      shift_q <= 8'h00;
      sda_oe_n <= 1'b1;
    end else if (start_det) begin
      // repeated start drops a partial word
      st_q <= QDAC_I2C_ADDR;
      bit_cnt_q <= 4'h0;
      byte_cnt_q <= 2'h0;
      sda_oe_n <= 1'b1;
    end else if (stop_det) begin
      st_q <= QDAC_I2C_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      case (st_q)
        QDAC_I2C_ADDR, QDAC_I2C_DATA: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s}; // msb first
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_done) begin
            if (st_q == QDAC_I2C_ADDR) begin
              st_q <= addr_hit ? QDAC_I2C_ACK : QDAC_I2C_SKIP;
              sda_oe_n <= !addr_hit;
            end else if (byte_cnt_q == 2'd3) begin
              st_q <= QDAC_I2C_SKIP; // extra byte left released
            end else begin
              st_q <= QDAC_I2C_ACK;
              sda_oe_n <= 1'b0;
              byte_cnt_q <= byte_cnt_q + 2'h1;
            end
          end
        end
        QDAC_I2C_ACK: begin
          // release at the fall that ends the ninth clock
          if (scl_fall) begin
            sda_oe_n <= 1'b1;
            st_q <= QDAC_I2C_DATA;
            bit_cnt_q <= 4'h0;
          end
        end
        QDAC_I2C_SKIP, QDAC_I2C_IDLE: begin
          sda_oe_n <= 1'b1;
        end
        default: begin
          st_q <= QDAC_I2C_IDLE;
          sda_oe_n <= 1'b1;
        end
      endcase
    end
  end
  assign sda_out = 1'b0;

  // word assembly; execution fires only on the third byte
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      word_q <= 24'h000000;
      exec_q <= 1'b0;
    end else begin
      exec_q <= 1'b0;
      if (st_q == QDAC_I2C_DATA && byte_done && byte_cnt_q != 2'd3 &&
          !start_det && !stop_det) begin
        word_q <= {word_q[15:0], shift_q};
        exec_q <= (byte_cnt_q == 2'd2);
      end
    end
  end

  // field split of the executed word
  assign cmd = word_q[23:20];
  assign sel = word_q[19:16];
  assign data = word_q[15:0];

  // reserved codes select nothing and act as no-ops, except that write-update-all still updates every channel
  always_comb begin
    case (sel)
      4'h0: sel_mask = 4'b0001;
      4'h1: sel_mask = 4'b0010;
      4'h2: sel_mask = 4'b0100;
      4'h3: sel_mask = 4'b1000;
      4'hf: sel_mask = 4'b1111;
      default: sel_mask = 4'b0000;
    endcase
    wr_mask = 4'h0;
    upd_mask = 4'h0;
    pd_mask = 4'h0;
    case (cmd)
      QDAC_CMD_WRITE: wr_mask = sel_mask;
      QDAC_CMD_UPDATE: upd_mask = sel_mask;
      QDAC_CMD_WRITE_UPD_ALL: begin
        wr_mask = sel_mask;
        upd_mask = 4'hf;
      end
      QDAC_CMD_WRITE_UPD: begin
        wr_mask = sel_mask;
        upd_mask = sel_mask;
      end
      QDAC_CMD_POWER_DOWN: pd_mask = sel_mask;
      default: begin
      end
    endcase
    if (!exec_q) begin
      wr_mask = 4'h0;
      upd_mask = 4'h0;
      pd_mask = 4'h0;
    end
  end

  // bias shuts off only when every channel is down
  assign pu_delay = !(&pd_q) ? PU_SHORT_CYC :
                    low_supply_q ? PU_LONG3_CYC : PU_LONG5_CYC;

  // per-channel register pair, power state and wake timer
  for (genvar i = 0; i < 4; i++) begin : g_chan
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        input_q[i] <= RST_CODE;
        dac_q[i] <= RST_CODE;
      end else begin
        if (wr_mask[i]) input_q[i] <= data;
        // same-word write goes straight through on update
        if (upd_mask[i])
          dac_q[i] <= wr_mask[i] ? data : input_q[i];
      end
    end
    // power changes touch no code register
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        pd_q[i] <= 1'b0;
        pu_cnt_q[i] <= 11'h000;
      end else if (upd_mask[i]) begin
        pd_q[i] <= 1'b0;
        if (pd_q[i]) pu_cnt_q[i] <= pu_delay;
      end else begin
        if (pd_mask[i]) pd_q[i] <= 1'b1;
        if (pu_cnt_q[i] != 11'h000)
          pu_cnt_q[i] <= pu_cnt_q[i] - 11'h001;
      end
    end
    assign dac_code[i] = dac_q[i];
    assign chan_settling[i] = (pu_cnt_q[i] != 11'h000);
  end

  // powered-down channel loses buffer and reference
  assign chan_buf_en = ~pd_q;
  assign channel_reference_input_en = ~pd_q;
  assign chan_out_hiz = pd_q;
  assign bias_en = !(&pd_q);

  // ahb-lite slave: zero wait, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ahb_take = hsel && hready && htrans[1];

  // address phase capture; read data fetched at the same edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ahb_wr_q <= 1'b0;
      ahb_addr_q <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      ahb_wr_q <= ahb_take && hwrite;
      ahb_addr_q <= haddr[7:0];
      if (ahb_take && !hwrite) begin
        hrdata <= 32'h00000000;
        if (haddr[7:0] == `QDAC_OFS_CTRL)
          hrdata <= {31'h0, low_supply_q};
        else if (haddr[7:0] == `QDAC_OFS_STATUS)
          hrdata <= {9'h0, own_addr, 6'h0, addr_ready, bias_en,
                     chan_settling, pd_q};
        else if (haddr[7:0] == `QDAC_OFS_WORD)
          hrdata <= {8'h0, word_q};
        else if (haddr[7:4] == `QDAC_PAGE_DAC && haddr[3:2] != 2'h0 ||
                 haddr[7:4] == `QDAC_PAGE_DAC)
          hrdata <= {16'h0, dac_q[haddr[3:2]]};
        else if (haddr[7:4] == `QDAC_PAGE_INPUT)
          hrdata <= {16'h0, input_q[haddr[3:2]]};
      end
    end
  end

  // only the supply select is writable; it steers the wake time
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      low_supply_q <= `QDAC_CTRL_RST;
    end else if (ahb_wr_q && ahb_addr_q == `QDAC_OFS_CTRL) begin
      low_supply_q <= hwdata[`QDAC_CTRL_LOW_SUPPLY];
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_addr_byte;
    st_q == QDAC_I2C_ADDR && byte_done && !start_det && !stop_det;
  endsequence
  sequence s_data_byte;
    st_q == QDAC_I2C_DATA && byte_done && !start_det && !stop_det;
  endsequence

  addr_match_a: assert property (s_addr_byte |=>
    (!sda_oe_n == $past(addr_hit)))
    else $error("address acknowledge does not follow match");
  data_ack_a: assert property (s_data_byte ##0 (byte_cnt_q < 2'd3)
    |=> !sda_oe_n && st_q == QDAC_I2C_ACK)
    else $error("data byte not acknowledged");
  exec_third_a: assert property ($rose(exec_q) |->
    byte_cnt_q == 2'd3 && $past(st_q) == QDAC_I2C_DATA)
    else $error("execution before third byte");
  extra_nack_a: assert property (s_data_byte ##0 (byte_cnt_q == 2'd3)
    |=> sda_oe_n && st_q == QDAC_I2C_SKIP [*2])
    else $error("extra byte acknowledged");
  read_nack_a: assert property (s_addr_byte ##0 shift_q[0]
    |=> sda_oe_n)
    else $error("read acknowledged");
  write_in_a: assert property (exec_q && cmd == 4'h0 && sel == 4'h2
    |=> input_q[2] == $past(data) && dac_q[2] == $past(dac_q[2]))
    else $error("write to input register failed");
  update_a: assert property (exec_q && cmd == 4'h1 && sel == 4'h1
    |=> dac_q[1] == $past(input_q[1]) && !pd_q[1])
    else $error("update did not copy input register");
  pd_keep_a: assert property (exec_q && cmd == 4'h4 && sel == 4'hf
    |=> &pd_q && $stable(dac_q[0]) && $stable(input_q[3]))
    else $error("power-down changed codes");
  hiz_a: assert property (pd_q[3] |-> chan_out_hiz[3] &&
    !chan_buf_en[3] && !channel_reference_input_en[3])
    else $error("powered-down channel still driven");
  wake_short_a: assert property (upd_mask[1] && pd_q[1] && !(&pd_q)
    |=> pu_cnt_q[1] == PU_SHORT_CYC ##1 chan_settling[1])
    else $error("short power-up delay wrong");
  wake_long_a: assert property (upd_mask[0] && &pd_q
    |=> pu_cnt_q[0] == ($past(low_supply_q) ? PU_LONG3_CYC
                                             : PU_LONG5_CYC))
    else $error("long power-up delay wrong");
  no_exec_a: assert property ((stop_det || start_det) &&
    st_q == QDAC_I2C_DATA && byte_cnt_q < 2'd3 |=> !exec_q)
    else $error("short transaction executed");
endmodule : qdac_top

// File: verification/qdac_i2c_master.sv
// Purpose: i2c master model driving write transfers into the dac unit
// Assumes: sda wire has a pull-up; 160 ns link clock, idle high
// Notes: link clock stands still outside frames
`timescale 1ns/1ps
module qdac_i2c_master (
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  localparam realtime Q = 40.0; // quarter link period
  // both lines idle high; sda released to the pull-up, scl driven
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // extra low time lets a pending ack be released first
  task automatic start();
    sda_drv = 1'b1;
    #(2*Q);
    scl = 1'b1;
    #Q;
    sda_drv = 1'b0;
    #Q;
    scl = 1'b0;
    #Q;
  endtask : start
  task automatic stop();
    sda_drv = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_drv = 1'b1;
    #(2*Q);
  endtask : stop
  // data changes only while the clock is low
  task automatic put_bit(input logic b, output logic s);
    sda_drv = b;
    #Q;
    scl = 1'b1;
    #Q;
    s = sda_line;
    #Q;
    scl = 1'b0;
    #Q;
  endtask : put_bit
  // msb first, then release for the ninth clock
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask : put_byte
endmodule : qdac_i2c_master

// File: verification/tb.sv
// Purpose: self-checking bench of the quad dac write command unit
// Assumes: address pin 2 tied high, pin 1 floating, pin 0 tied low
// Notes: random words from a fixed-seed xorshift
`timescale 1ns/1ps
module tb;
  import qdac_pkg::*;
  logic sys_clk, sys_rst, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rnd_q, r;
  logic [1:0] htrans;
  logic [2:0] hsize, p_out, p_oe_n, p_in;
  logic scl, sda_drv, sda_oe_n, sda_out, bias_en;
  logic [3:0] buf_en, ref_en, hiz, settling, e_pd;
  logic [15:0] e_in [4];
  logic [15:0] e_dac [4];
  qdac_code_t dac_code [4];
  logic [4:0] k;
  logic [23:0] wrd;
  logic [3:0] cmds [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hf};
  logic [3:0] sels [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hf};
  logic [6:0] own;
  int fail_count, cmp_count, set_cnt;
  // wired-and with pull-up; floating pin 1 follows the probe drive
  wire logic sda_line = sda_drv & (sda_oe_n | sda_out);
  assign p_in = {1'b1, p_oe_n[1] ? ~p_out[1] : p_out[1], 1'b0};
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  qdac_i2c_master m (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
  qdac_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_select_pin_0_in(p_in[0]), .addr_select_pin_0_out(p_out[0]),
    .addr_select_pin_0_oe_n(p_oe_n[0]),
    .addr_select_pin_1_in(p_in[1]), .addr_select_pin_1_out(p_out[1]),
    .addr_select_pin_1_oe_n(p_oe_n[1]),
    .addr_select_pin_2_in(p_in[2]), .addr_select_pin_2_out(p_out[2]),
    .addr_select_pin_2_oe_n(p_oe_n[2]), .dac_code(dac_code),
    .chan_buf_en(buf_en), .channel_reference_input_en(ref_en),
    .chan_out_hiz(hiz), .chan_settling(settling), .bias_en(bias_en));
  // cycles with any channel settling
  always @(posedge sys_clk) if (settling != 4'h0) set_cnt <= set_cnt + 1;
  function automatic logic [31:0] rnd();
    rnd_q ^= rnd_q << 13;
    rnd_q ^= rnd_q >> 17;
    rnd_q ^= rnd_q << 5;
    return rnd_q;
  endfunction : rnd
  function automatic void exp_apply(input logic [23:0] w);
    logic [3:0] c, s, sel;
    c = w[23:20];
    s = w[19:16];
    sel = (s == 4'hf) ? 4'hf : (s < 4'h4) ? 4'h1 << s : 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (sel[i] && (c == 4'h0 || c == 4'h2 || c == 4'h3))
        e_in[i] = w[15:0];
      if (sel[i] && c == 4'h4) e_pd[i] = 1'b1;
    end
    for (int i = 0; i < 4; i++) begin
      if ((sel[i] && (c == 4'h1 || c == 4'h3)) || c == 4'h2) begin
        e_dac[i] = e_in[i];
        e_pd[i] = 1'b0;
      end
    end
  endfunction : exp_apply
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // single word transfer; waits on hready, data taken at second edge
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'b010;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask : ahb
  // address byte, nb data bytes (extra ones random), then stop
  task automatic xfer(input logic [7:0] ab, input int nb,
                      input logic [23:0] w, output logic [4:0] a);
    a = '0;
    m.start();
    m.put_byte(ab, a[0]);
    for (int i = 0; i < nb; i++)
      m.put_byte(i < 3 ? w[23 - 8 * i -: 8] : rnd_q[7:0], a[i + 1]);
    m.stop();
  endtask : xfer
  task automatic check_state();
    for (int i = 0; i < 4; i++) begin
      check({16'h0, dac_code[i]}, {16'h0, e_dac[i]});
      ahb(1'b0, 32'h20 + 32'(4 * i), 32'h0, r);
      check(r, {16'h0, e_in[i]});
    end
    check({24'h0, hiz, buf_en}, {24'h0, e_pd, ~e_pd});
    check({28'h0, ref_en}, {28'h0, ~e_pd});
    check({31'h0, bias_en}, {31'h0, ~&e_pd});
  endtask : check_state
  task automatic word(input logic [23:0] w);
    xfer({own, 1'b0}, 3, w, k);
    exp_apply(w);
    check({27'h0, k}, 32'h0f);
  endtask : word
  // settle cycles must match the power-up delay at 50 MHz
  // an older delay still running would inflate the count, so wait it out
  task automatic settle(input logic [23:0] w, input int n);
    while (settling != 4'h0) @(posedge sys_clk);
    set_cnt = 0;
    word(w);
    repeat (n + 40) @(posedge sys_clk);
    check(32'(set_cnt >= n - 2 && set_cnt <= n + 2), 32'h1);
    check_state();
  endtask : settle
  task automatic test_done();
    $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  // a hang ends in the same verdict
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    sys_rst = 1'b1;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    rnd_q = 32'd45;
    e_pd = 4'h0;
    for (int i = 0; i < 4; i++) begin
      e_in[i] = 16'h0000;
      e_dac[i] = 16'h0000;
    end
    own = 7'h61; // pin 2 high, pin 1 floating, pin 0 low
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 4; i++) check({16'h0, dac_code[i]}, 32'h0);
    ahb(1'b0, 32'h0, 32'h0, r);
    check(r, 32'h0); // ctrl reset value
    check({31'h0, hresp}, 32'h0); // okay response
    repeat (40) @(posedge sys_clk);
    ahb(1'b0, 32'h4, 32'h0, r);
    check({25'h0, r[22:16]}, {25'h0, own});
    check({31'h0, r[9]}, 32'h1);
    ahb(1'b0, 32'h40, 32'h0, r);
    check(r, 32'h0); // unmapped read
    $display("test reset done");
    xfer({own ^ 7'h01, 1'b0}, 3, 24'h3f1234, k);
    check({31'h0, k[0]}, 32'h0);
    check_state();
    xfer({own, 1'b1}, 0, 24'h0, k);
    check({31'h0, k[0]}, 32'h0);
    xfer({7'h73, 1'b0}, 3, 24'h3f0000 | 24'(rnd_q[15:0]), k);
    exp_apply(24'h3f0000 | 24'(rnd_q[15:0]));
    check({27'h0, k}, 32'h0f);
    check_state();
    $display("test addressing done");
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      wrd = {i < 6 ? cmds[i] : cmds[r[29:20] % 6], sels[r[19:16] % 5],
             r[15:0]};
      xfer({r[31] ? 7'h73 : own, 1'b0}, 3 + 32'(r[30]), wrd, k);
      exp_apply(wrd);
      check({27'h0, k}, 32'h0f);
      check_state();
    end
    $display("test random words done");
    xfer({own, 1'b0}, 4, 24'h3f00ff, k);
    exp_apply(24'h3f00ff);
    check({27'h0, k}, 32'h0f);
    check_state();
    xfer({own, 1'b0}, 2, 24'h3fabcd, k);
    check({27'h0, k}, 32'h07);
    check_state();
    $display("test short transfer done");
    word(24'h4f5555);
    check_state();
    settle(24'h100000, 600);
    word(24'h410000);
    settle(24'h110000, 250);
    ahb(1'b1, 32'h0, 32'h1, r);
    ahb(1'b0, 32'h0, 32'h0, r);
    check(r, 32'h1); // low supply bit
    word(24'h4f0000);
    settle({8'h2f, rnd_q[15:0]}, 1500);
    $display("test power down done");
    test_done();
  end
endmodule : tb
